// ===== core/emb_defs.vh
// Constants for the external memory bus timing block.
// Assumes inclusion by bare name from the address select and sequencer files of the block.
// How it works
// - Mode codes 101, 110, 111 run 16-bit transfers non-multiplexed.
// - Mode codes 101 and 111 run 8-bit non-multiplexed transfers without bank select.
// - Mode code 110 runs 8-bit non-multiplexed transfers with bank select.
// - Mode codes 001, 010, 011 run 16-bit transfers multiplexed.
// - Mode codes 001 and 011 run 8-bit multiplexed transfers without bank select.
// - Mode code 010 runs 8-bit multiplexed transfers with bank select.
// - Non-multiplexed 16-bit: pointer high byte on port 5, low byte on port 6.
// - Non-multiplexed: data on port 7, driven on writes, sampled on reads.
// - Bank select: high byte from page select, low byte from indirect pointer.
// - Active-low write strobe on P4.7, read strobe on P4.6; only one pulses.
// - Multiplexed: port 7 carries low address first, then data.
// - Multiplexed: latch strobe on P4.5 captures the low address byte.
// - Multiplexed: upper address byte goes on port 6, not port 5.
// - Setup of 0 to 3 clocks before the strobe.
// - Strobe width of 1 to 16 clocks.
// - Hold of 0 to 3 clocks after the strobe.
// - Latch strobe high for 1 to 4 clocks in multiplexed mode.
// - Latch strobe low for 1 to 4 clocks before the data phase.
// - Write data valid 1 to 19 clocks before the write strobe rises.
// - Write data held 0 to 3 clocks after the write strobe rises.
// - Upper ports act as bus pins only during off-chip moves.
// - A transfer takes 4 clocks beyond the programmed phases.
// - After reset the timing settings take their maximum values.
// - 8-bit transfers without bank select leave the upper byte undriven.
`ifndef EMB_DEFS_VH
`define EMB_DEFS_VH
`define EMB_MODE_MUX_BS      3'b010
`define EMB_MODE_NMX_BS      3'b110
`define EMB_MODE_MUX_BIT     2
`define EMB_TIM_SETUP_HI     7
`define EMB_TIM_SETUP_LO     6
`define EMB_TIM_WIDTH_HI     5
`define EMB_TIM_WIDTH_LO     2
`define EMB_TIM_HOLD_HI      1
`define EMB_TIM_HOLD_LO      0
`define EMB_ALE_HIGH_HI      3
`define EMB_ALE_HIGH_LO      2
`define EMB_ALE_LOW_HI       1
`define EMB_ALE_LOW_LO       0
`define EMB_TIM_RESET        8'hff
`define EMB_ALE_RESET        4'hf
`define EMB_OVERHEAD_CYC     4
`endif

// ===== core/emb_down_cnt.v
// Loadable down counter used to time each bus phase.
// Assumes one clock, synchronous active-low reset and a clock enable.
`timescale 1ns/10ps
module emb_down_cnt #(
    parameter W = 5
) (
    input  wire         clk_sys,
    input  wire         rst_n,
    input  wire         ce,
    input  wire         load,
    input  wire [W-1:0] load_val,
    output wire         zero
);
    reg [W-1:0] cnt_r;
    assign zero = (cnt_r == {W{1'b0}});
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_r <= {W{1'b0}};
        end else if (ce) begin
            if (load) begin
                cnt_r <= load_val;
            end else if (!zero) begin
                cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ===== core/emb_addr_sel.v
// Combinational address source selection for one transfer.
// Assumes the mode code and pointer bytes are stable while a request is taken.
`include "emb_defs.vh"
`timescale 1ns/10ps
module emb_addr_sel (
    input  wire [2:0] mode,
    input  wire       wide,
    input  wire       ptr_sel,
    input  wire [7:0] pointer_high_byte,
    input  wire [7:0] pointer_low_byte,
    input  wire [7:0] indirect_ptr_zero,
    input  wire [7:0] indirect_ptr_one,
    input  wire [7:0] ext_mem_page_select,
    output reg  [7:0] addr_hi,
    output reg  [7:0] addr_lo,
    output reg        hi_drive
);
    always @* begin
        if (wide) begin
            addr_hi  = pointer_high_byte;
            addr_lo  = pointer_low_byte;
            hi_drive = 1'b1;
        end else begin
            addr_hi  = ext_mem_page_select;
            addr_lo  = ptr_sel ? indirect_ptr_one : indirect_ptr_zero;
            // Without bank select the upper byte is left to the port.
            hi_drive = (mode == `EMB_MODE_NMX_BS) || (mode == `EMB_MODE_MUX_BS);
        end
    end
endmodule

// ===== core/emb_ctrl.v
// External memory bus sequencer for off-chip external moves.
// Assumes the core holds request fields stable until done, and drives pins itself when not busy.
`include "emb_defs.vh"
`timescale 1ns/10ps
module emb_ctrl #(
    parameter CW = 5
) (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       ce,
    input  wire       req,
    input  wire       req_write,
    input  wire       req_wide,
    input  wire       req_ptr_sel,
    input  wire [7:0] wdata,
    input  wire [2:0] ext_mem_config,
    input  wire [7:0] ext_mem_page_select,
    input  wire [7:0] ext_mem_timing_ctrl,
    input  wire       timing_load,
    input  wire [3:0] ale_timing,
    input  wire [7:0] pointer_high_byte,
    input  wire [7:0] pointer_low_byte,
    input  wire [7:0] indirect_ptr_zero,
    input  wire [7:0] indirect_ptr_one,
    input  wire [7:0] p7_in,
    output reg  [7:0] p5_out,
    output reg        p5_oe,
    output reg  [7:0] p6_out,
    output reg        p6_oe,
    output reg  [7:0] p7_out,
    output reg        p7_oe,
    output reg        p4_wr_n,
    output reg        p4_rd_n,
    output reg        p4_ale,
    output reg        bus_active,
    output reg  [7:0] rdata,
    output reg        done
);
    localparam S_IDLE  = 3'd0;
    localparam S_ALEH  = 3'd1;
    localparam S_ALEL  = 3'd2;
    localparam S_SETUP = 3'd3;
    localparam S_STRB  = 3'd4;
    localparam S_HOLD  = 3'd5;
    localparam S_TAIL  = 3'd6;

    reg [2:0]  st_r;
    reg [2:0]  st_nxt;
    reg [7:0]  tim_r;
    reg [3:0]  ale_r;
    reg        wr_r;
    reg        load;
    reg [CW-1:0] load_val;
    wire       cnt_zero;
    wire [7:0] sel_hi;
    wire [7:0] sel_lo;
    wire       sel_hidrv;

    localparam [CW-1:0] TAIL_LEN = `EMB_OVERHEAD_CYC;

    // Phase length minus one so that a count of zero lasts one cycle.
    function [CW-1:0] len_m1;
        input [CW-1:0] cycles;
        begin
            len_m1 = cycles - {{(CW-1){1'b0}}, 1'b1};
        end
    endfunction

    emb_addr_sel u_sel (
        .mode                (ext_mem_config),
        .wide                (req_wide),
        .ptr_sel             (req_ptr_sel),
        .pointer_high_byte   (pointer_high_byte),
        .pointer_low_byte    (pointer_low_byte),
        .indirect_ptr_zero   (indirect_ptr_zero),
        .indirect_ptr_one    (indirect_ptr_one),
        .ext_mem_page_select (ext_mem_page_select),
        .addr_hi             (sel_hi),
        .addr_lo             (sel_lo),
        .hi_drive            (sel_hidrv)
    );

    emb_down_cnt #(.W(CW)) u_cnt (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .ce       (ce),
        .load     (load),
        .load_val (load_val),
        .zero     (cnt_zero)
    );

    wire [1:0] t_setup = tim_r[`EMB_TIM_SETUP_HI:`EMB_TIM_SETUP_LO];
    wire [3:0] t_width = tim_r[`EMB_TIM_WIDTH_HI:`EMB_TIM_WIDTH_LO];
    wire [1:0] t_hold  = tim_r[`EMB_TIM_HOLD_HI:`EMB_TIM_HOLD_LO];
    wire [1:0] latch_strobe_high  = ale_r[`EMB_ALE_HIGH_HI:`EMB_ALE_HIGH_LO];
    wire [1:0] latch_strobe_low  = ale_r[`EMB_ALE_LOW_HI:`EMB_ALE_LOW_LO];
    wire [CW-1:0] setup_m1 = len_m1({{(CW-2){1'b0}}, t_setup});
    wire [CW-1:0] hold_m1  = len_m1({{(CW-2){1'b0}}, t_hold});
    wire [CW-1:0] width_ld = {{(CW-4){1'b0}}, t_width};

    // Next state and counter loads; each phase waits for the counter to reach zero.
    always @* begin
        st_nxt   = st_r;
        load     = 1'b0;
        load_val = {CW{1'b0}};
        case (st_r)
            S_IDLE: begin
                if (req) begin
                    load = 1'b1;
                    if (ext_mem_config[`EMB_MODE_MUX_BIT] == 1'b0) begin
                        st_nxt   = S_ALEH;
                        load_val = {{(CW-2){1'b0}}, latch_strobe_high};
                    end else if (t_setup == 2'd0) begin
                        st_nxt   = S_STRB;
                        load_val = width_ld;
                    end else begin
                        st_nxt   = S_SETUP;
                        load_val = setup_m1;
                    end
                end
            end
            S_ALEH: begin
                if (cnt_zero) begin
                    st_nxt   = S_ALEL;
                    load     = 1'b1;
                    load_val = {{(CW-2){1'b0}}, latch_strobe_low};
                end
            end
            S_ALEL: begin
                if (cnt_zero) begin
                    load = 1'b1;
                    if (t_setup == 2'd0) begin
                        st_nxt   = S_STRB;
                        load_val = width_ld;
                    end else begin
                        st_nxt   = S_SETUP;
                        load_val = setup_m1;
                    end
                end
            end
            S_SETUP: begin
                if (cnt_zero) begin
                    st_nxt   = S_STRB;
                    load     = 1'b1;
                    load_val = width_ld;
                end
            end
            S_STRB: begin
                if (cnt_zero) begin
                    load = 1'b1;
                    if (t_hold == 2'd0) begin
                        st_nxt   = S_TAIL;
                        load_val = len_m1(TAIL_LEN);
                    end else begin
                        st_nxt   = S_HOLD;
                        load_val = hold_m1;
                    end
                end
            end
            S_HOLD: begin
                if (cnt_zero) begin
                    st_nxt   = S_TAIL;
                    load     = 1'b1;
                    load_val = len_m1(TAIL_LEN);
                end
            end
            S_TAIL: begin
                if (cnt_zero) begin
                    st_nxt = S_IDLE;
                end
            end
            default: begin
                st_nxt = S_IDLE;
            end
        endcase
    end

    // A zero setup or hold skips its phase, so setup and hold each last exactly their programmed number of cycles.

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r       <= S_IDLE;
            tim_r      <= `EMB_TIM_RESET;
            ale_r      <= `EMB_ALE_RESET;
            wr_r       <= 1'b0;
            p5_out     <= 8'h00;
            p5_oe      <= 1'b0;
            p6_out     <= 8'h00;
            p6_oe      <= 1'b0;
            p7_out     <= 8'h00;
            p7_oe      <= 1'b0;
            p4_wr_n    <= 1'b1;
            p4_rd_n    <= 1'b1;
            p4_ale     <= 1'b0;
            bus_active <= 1'b0;
            rdata      <= 8'h00;
            done       <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            done <= 1'b0;
            if (timing_load && st_r == S_IDLE) begin
                tim_r <= ext_mem_timing_ctrl;
                ale_r <= ale_timing;
            end
            if (st_r == S_IDLE && req) begin
                wr_r       <= req_write;
                bus_active <= 1'b1;
                if (ext_mem_config[`EMB_MODE_MUX_BIT] == 1'b0) begin
                    p6_out <= sel_hi;
                    p6_oe  <= sel_hidrv;
                    p7_out <= sel_lo;
                    p7_oe  <= 1'b1;
                    p4_ale <= 1'b1;
                end else begin
                    p5_out <= sel_hi;
                    p5_oe  <= sel_hidrv;
                    p6_out <= sel_lo;
                    p6_oe  <= 1'b1;
                    p7_out <= wdata;
                    p7_oe  <= req_write;
                    if (t_setup == 2'd0) begin
                        p4_wr_n <= ~req_write;
                        p4_rd_n <= req_write;
                    end
                end
            end
            if (st_r == S_ALEH && cnt_zero) begin
                p4_ale <= 1'b0;
            end
            if (st_r == S_ALEL && cnt_zero) begin
                // Address phase over on the shared port; data phase follows.
                p7_out <= wdata;
                p7_oe  <= wr_r;
                if (t_setup == 2'd0) begin
                    p4_wr_n <= ~wr_r;
                    p4_rd_n <= wr_r;
                end
            end
            if (st_r == S_SETUP && cnt_zero) begin
                p4_wr_n <= ~wr_r;
                p4_rd_n <= wr_r;
            end
            if (st_r == S_STRB && cnt_zero) begin
                p4_wr_n <= 1'b1;
                p4_rd_n <= 1'b1;
                if (!wr_r) begin
                    rdata <= p7_in;
                end
                if (t_hold == 2'd0) begin
                    p5_oe <= 1'b0;
                    p6_oe <= 1'b0;
                    p7_oe <= 1'b0;
                end
            end
            if (st_r == S_HOLD && cnt_zero) begin
                p5_oe  <= 1'b0;
                p6_oe  <= 1'b0;
                p7_oe  <= 1'b0;
            end
            if (st_r == S_TAIL && cnt_zero) begin
                bus_active <= 1'b0;
                done       <= 1'b1;
            end
        end
    end
endmodule

// ===== sim/emb_ctrl_assertions.sv
// Port checker for the external memory bus sequencer.
// Assumes timing is loaded only while the bus is idle.
`timescale 1ns/10ps
module emb_ctrl_chk (
    input wire       clk_sys,
    input wire       rst_n,
    input wire       ce,
    input wire       req_wide,
    input wire       timing_load,
    input wire [3:0] ale_timing,
    input wire [7:0] wdata,
    input wire [2:0] ext_mem_config,
    input wire [7:0] ext_mem_page_select,
    input wire [7:0] ext_mem_timing_ctrl,
    input wire [7:0] pointer_high_byte,
    input wire [7:0] pointer_low_byte,
    input wire [7:0] p5_out,
    input wire       p5_oe,
    input wire [7:0] p6_out,
    input wire       p6_oe,
    input wire [7:0] p7_out,
    input wire       p7_oe,
    input wire       p4_wr_n,
    input wire       p4_rd_n,
    input wire       p4_ale,
    input wire       bus_active,
    input wire       done
);
    reg  [7:0] tim_r;
    reg  [4:0] low_r;
    reg  [3:0] ale_t_r;
    reg  [2:0] ale_n_r;
    wire       stb = !p4_wr_n || !p4_rd_n;
    wire       nmx = ext_mem_config[2];
    wire       bsel = ext_mem_config[1:0] == 2'b10;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            tim_r   <= 8'hff;
            ale_t_r <= 4'hf;
            low_r   <= 5'h00;
            ale_n_r <= 3'h0;
        end else if (ce) begin
            if (timing_load && !bus_active) begin
                tim_r   <= ext_mem_timing_ctrl;
                ale_t_r <= ale_timing;
            end
            low_r   <= stb ? low_r + 5'h01 : 5'h00;
            ale_n_r <= p4_ale ? ale_n_r + 3'h1 : 3'h0;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_strobe_one: assert property (p4_wr_n || p4_rd_n)
        else $error("both strobes low");
    a_strobe_width: assert property ($rose(p4_wr_n && p4_rd_n) |-> low_r == tim_r[5:2] + 5'h01)
        else $error("strobe width wrong");
    a_idle_release: assert property (!bus_active |-> !stb && !p5_oe && !p6_oe && !p7_oe)
        else $error("pins driven while idle");
    a_wdata_on: assert property (!p4_wr_n |-> p7_oe && p7_out == wdata)
        else $error("write data missing");
    a_rd_release: assert property (!p4_rd_n |-> !p7_oe)
        else $error("data port driven in read");
    a_nmx_addr: assert property (stb && nmx && req_wide |-> p5_oe && p5_out == pointer_high_byte
                                 && p6_out == pointer_low_byte)
        else $error("wide address wrong");
    a_mux_addr: assert property (stb && !nmx && req_wide |-> !p5_oe && p6_out == pointer_high_byte)
        else $error("muxed high byte wrong");
    a_bank_hi: assert property (stb && bsel && !req_wide |-> (nmx ? p5_out : p6_out) == ext_mem_page_select)
        else $error("page byte wrong");
    a_nobank_hi: assert property (stb && !bsel && !req_wide |-> !(nmx ? p5_oe : p6_oe))
        else $error("upper byte driven");
    a_ale_mux: assert property (p4_ale |-> !nmx && p7_oe && !stb)
        else $error("latch strobe misplaced");
    a_ale_high: assert property ($fell(p4_ale) |-> ale_n_r == {1'b0, ale_t_r[3:2]} + 3'h1)
        else $error("latch strobe width wrong");
    a_done_pulse: assert property (done |=> !done ##1 !done)
        else $error("done too long");
endmodule
bind emb_ctrl emb_ctrl_chk i_emb_ctrl_chk (
    .clk_sys             (clk_sys),
    .rst_n               (rst_n),
    .ce                  (ce),
    .req_wide            (req_wide),
    .timing_load         (timing_load),
    .ale_timing          (ale_timing),
    .wdata               (wdata),
    .ext_mem_config      (ext_mem_config),
    .ext_mem_page_select (ext_mem_page_select),
    .ext_mem_timing_ctrl (ext_mem_timing_ctrl),
    .pointer_high_byte   (pointer_high_byte),
    .pointer_low_byte    (pointer_low_byte),
    .p5_out              (p5_out),
    .p5_oe               (p5_oe),
    .p6_out              (p6_out),
    .p6_oe               (p6_oe),
    .p7_out              (p7_out),
    .p7_oe               (p7_oe),
    .p4_wr_n             (p4_wr_n),
    .p4_rd_n             (p4_rd_n),
    .p4_ale              (p4_ale),
    .bus_active          (bus_active),
    .done                (done)
);

// ===== sim/emb_sram_model.sv
// Asynchronous memory behind the external bus, with an address latch.
// Assumes weak pull-ups on every port pin.
`timescale 1ns/10ps
module emb_sram_model (
    input  wire       clk_sys,
    input  wire       mux,
    input  wire       slow,
    input  wire [7:0] p5_out,
    input  wire       p5_oe,
    input  wire [7:0] p6_out,
    input  wire       p6_oe,
    input  wire [7:0] p7_out,
    input  wire       p7_oe,
    input  wire       p4_wr_n,
    input  wire       p4_rd_n,
    input  wire       p4_ale,
    output wire [7:0] p7_in
);
    reg  [7:0]  mem [0:65535];
    reg  [7:0]  lat_r;
    reg  [2:0]  wait_r;
    wire [7:0]  p5 = p5_oe ? p5_out : 8'hff;
    wire [7:0]  p6 = p6_oe ? p6_out : 8'hff;
    wire [15:0] addr = mux ? {p6, lat_r} : {p5, p6};
    // A slow part shows the pull-up level until its access time has run.
    assign p7_in = p7_oe ? p7_out : (!p4_rd_n && (!slow || wait_r > 3'h1)) ? mem[addr] : 8'hff;
    always @(posedge clk_sys) begin
        if (p4_ale && p7_oe)
            lat_r <= p7_out;
        if (!p4_wr_n && p7_oe)
            mem[addr] <= p7_out;
        wait_r <= p4_rd_n ? 3'h0 : wait_r + {2'h0, wait_r != 3'h7};
    end
endmodule

// ===== sim/tb_external_memory_bus_timing.sv
// Self-checking bench for the external memory bus sequencer.
// Assumes the memory model and the port checker sit beside the design.
`timescale 1ns/10ps
module tb_external_memory_bus_timing;
    reg        clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, req = 1'b0, req_write = 1'b0, req_wide = 1'b0;
    reg        req_ptr_sel = 1'b0, timing_load = 1'b0, mux = 1'b0, slow = 1'b0;
    reg  [7:0] wdata = 8'h00, ext_mem_page_select = 8'h56, ext_mem_timing_ctrl = 8'hff;
    reg  [7:0] pointer_high_byte = 8'h12, pointer_low_byte = 8'h34, indirect_ptr_zero = 8'h78;
    reg  [7:0] indirect_ptr_one = 8'h9a, cur_t = 8'hff;
    reg  [2:0] ext_mem_config = 3'b101;
    reg  [3:0] ale_timing = 4'hf, cur_a = 4'hf;
    wire [7:0] p7_in, p5_out, p6_out, p7_out, rdata;
    wire       p5_oe, p6_oe, p7_oe, p4_wr_n, p4_rd_n, p4_ale, bus_active, done;
    integer    fails = 0, n_checks = 0, lat, low, i, fz = 0;
    emb_ctrl i_emb_ctrl (
        .clk_sys             (clk_sys),
        .rst_n               (rst_n),
        .ce                  (ce),
        .req                 (req),
        .req_write           (req_write),
        .req_wide            (req_wide),
        .req_ptr_sel         (req_ptr_sel),
        .wdata               (wdata),
        .ext_mem_config      (ext_mem_config),
        .ext_mem_page_select (ext_mem_page_select),
        .ext_mem_timing_ctrl (ext_mem_timing_ctrl),
        .timing_load         (timing_load),
        .ale_timing          (ale_timing),
        .pointer_high_byte   (pointer_high_byte),
        .pointer_low_byte    (pointer_low_byte),
        .indirect_ptr_zero   (indirect_ptr_zero),
        .indirect_ptr_one    (indirect_ptr_one),
        .p7_in               (p7_in),
        .p5_out              (p5_out),
        .p5_oe               (p5_oe),
        .p6_out              (p6_out),
        .p6_oe               (p6_oe),
        .p7_out              (p7_out),
        .p7_oe               (p7_oe),
        .p4_wr_n             (p4_wr_n),
        .p4_rd_n             (p4_rd_n),
        .p4_ale              (p4_ale),
        .bus_active          (bus_active),
        .rdata               (rdata),
        .done                (done)
    );
    emb_sram_model i_emb_sram_model (
        .clk_sys (clk_sys),
        .mux     (mux),
        .slow    (slow),
        .p5_out  (p5_out),
        .p5_oe   (p5_oe),
        .p6_out  (p6_out),
        .p6_oe   (p6_oe),
        .p7_out  (p7_out),
        .p7_oe   (p7_oe),
        .p4_wr_n (p4_wr_n),
        .p4_rd_n (p4_rd_n),
        .p4_ale  (p4_ale),
        .p7_in   (p7_in)
    );
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task check(input bit ok, input string msg);
        n_checks = n_checks + 1;
        if (!ok) begin
            fails = fails + 1;
            $display("CHECK FAILED %0t %0s", $time, msg);
        end
    endtask
    task load_timing(input [7:0] t, input [3:0] a);
        @(negedge clk_sys);
        ext_mem_timing_ctrl = t;
        ale_timing = a;
        cur_t = t;
        cur_a = a;
        timing_load = 1'b1;
        @(negedge clk_sys);
        timing_load = 1'b0;
    endtask
    // Every transfer checks its length and strobe width against the settings in force.
    task xfer(input [2:0] c, input w, input wd, input s, input [7:0] d);
        @(negedge clk_sys);
        ext_mem_config = c;
        mux = !c[2];
        req_write = w;
        req_wide = wd;
        req_ptr_sel = s;
        wdata = d;
        req = 1'b1;
        lat = 0;
        low = 0;
        while (done !== 1'b1 && lat < 200) begin
            @(negedge clk_sys);
            lat = lat + 1;
            ce = !(lat <= fz);
            if (!(p4_wr_n && p4_rd_n))
                low = low + 1;
        end
        req = 1'b0;
        check(lat - 1 == 5 + fz + cur_t[7:6] + cur_t[5:2] + cur_t[1:0] + (mux ? cur_a[3:2] + cur_a[1:0] + 2 : 0),
              "transfer length");
        check(low == cur_t[5:2] + 1, "strobe width");
    endtask
    task t_modes;
        load_timing(8'h45, 4'h6);
        for (i = 1; i < 8; i = i + 1) begin
            if (i != 4) begin
                xfer(i[2:0], 1'b1, 1'b1, 1'b0, 8'h10 + i[7:0]);
                xfer(i[2:0], 1'b1, 1'b0, i[0], 8'h20 + i[7:0]);
                xfer(i[2:0], 1'b0, 1'b1, 1'b0, 8'h00);
                check(rdata === 8'h10 + i[7:0], "wide read back");
                xfer(i[2:0], 1'b0, 1'b0, i[0], 8'h00);
                check(rdata === 8'h20 + i[7:0], "narrow read back");
            end
        end
    endtask
    // Freezing the enable during setup stretches the transfer by the frozen cycles and loses nothing.
    task t_freeze;
        load_timing(8'h45, 4'h6);
        fz = 4;
        xfer(3'b110, 1'b1, 1'b0, 1'b1, 8'hc3);
        fz = 0;
        xfer(3'b110, 1'b0, 1'b0, 1'b1, 8'h00);
        check(rdata === 8'hc3, "frozen write read back");
    endtask
    task t_limits;
        load_timing(8'h00, 4'h0);
        xfer(3'b011, 1'b1, 1'b1, 1'b0, 8'h5a);
        xfer(3'b011, 1'b0, 1'b1, 1'b0, 8'h00);
        check(rdata === 8'h5a, "fast read");
        load_timing(8'hff, 4'hf);
        slow = 1'b1;
        xfer(3'b111, 1'b0, 1'b1, 1'b0, 8'h00);
        check(rdata === 8'h5a, "slow read");
        slow = 1'b0;
    endtask
    task wrap_up;
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        fails = fails + 1;
        wrap_up;
    end
    initial begin
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        check(p4_wr_n === 1'b1 && p4_rd_n === 1'b1 && p4_ale === 1'b0, "strobes idle");
        check(p5_oe === 1'b0 && p6_oe === 1'b0 && p7_oe === 1'b0 && done === 1'b0, "pins free");
        xfer(3'b101, 1'b1, 1'b1, 1'b0, 8'ha5);
        t_modes;
        t_freeze;
        t_limits;
        wrap_up;
    end
endmodule
